/* File: rtl/mts_converter.sv */
// Purpose: converter-side result pipeline, tag append and serial output with frame sync
// Assumes: bit clock, convert, tag and result inputs come from outside the clock domain
// Notes:   one sample pipeline delay; tag bits follow the 18th data bit
//
// Functional notes
// (R01) each result is shifted into a capture register, then held until next convert
// (R02) on convert, held result loads output register and shifts out on bit clock
// (R03) tag input bits shift into output register behind the outgoing result
// (R04) tag bits sit directly after the eighteenth data bit
// (R05) data sent after a convert belongs to the previous conversion
// (R06) far side: binary counter selects one of eight mux channels
// (R07) far side: convert delayed after each channel change for mux settling
// (R08) far side: channel identifier delayed one sample through a register
// (R09) far side: delay register optional only for sequential scans
// (R10) far side: tag register loads on rising bit clock qualified by frame sync
// (R11) far side: tag register shifts identifier into tag input on bit clock
// (R12) frame sync output is active low in the default format
// (R13) far side: format select high, frame sync inverted for other processors
// (R14) far side: channel counter advances once per cycle and wraps
// (R15) far side: settle timer issues exactly one convert on expiry
`timescale 1ns/10ps
module mts_converter
(
  input  wire logic I_SYS_CLK,
  input  wire logic I_RST_N,
  input  wire logic I_BIT_CLK,
  input  wire logic I_CONVERT,
  input  wire logic I_SAR_DATA,
  input  wire logic I_SAR_VALID,
  input  wire logic I_SAR_DONE,
  input  wire logic I_TAG,
  input  wire logic I_FRAME_FORMAT_SELECT,
  output logic      O_SERIAL_RESULT_OUTPUT,
  output logic      O_FRAME_SYNC,
  output logic      O_BUSY
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic bclk_s;
  logic conv_s;
  logic sard_s;
  logic sarv_s;
  logic sare_s;
  logic tag_s;
  logic fmt_s;

  mts_sync2 u_bclk (.i_clk(I_SYS_CLK), .i_rst_n(I_RST_N), .i_d(I_BIT_CLK),   .o_q(bclk_s));
  mts_sync2 u_conv (.i_clk(I_SYS_CLK), .i_rst_n(I_RST_N), .i_d(I_CONVERT),   .o_q(conv_s));
  mts_sync2 u_sard (.i_clk(I_SYS_CLK), .i_rst_n(I_RST_N), .i_d(I_SAR_DATA),  .o_q(sard_s));
  mts_sync2 u_sarv (.i_clk(I_SYS_CLK), .i_rst_n(I_RST_N), .i_d(I_SAR_VALID), .o_q(sarv_s));
  mts_sync2 u_sare (.i_clk(I_SYS_CLK), .i_rst_n(I_RST_N), .i_d(I_SAR_DONE),  .o_q(sare_s));
  mts_sync2 u_tag  (.i_clk(I_SYS_CLK), .i_rst_n(I_RST_N), .i_d(I_TAG),       .o_q(tag_s));
  mts_sync2 u_fmt  (.i_clk(I_SYS_CLK), .i_rst_n(I_RST_N),
                    .i_d(I_FRAME_FORMAT_SELECT), .o_q(fmt_s));

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    mts_pkg::mts_state_t            state;
    logic                           bclk_d;
    logic                           conv_d;
    logic                           sarv_d;
    logic                           sare_d;
    logic [mts_pkg::RESULT_W-1:0]   capture;
    logic [mts_pkg::RESULT_W-1:0]   held;
    logic [mts_pkg::FRAME_W-1:0]    out_sr;
    logic [mts_pkg::CNT_W-1:0]      bit_cnt;
    logic                           serial_result_output;
    logic                           sync_act;
    logic                           busy;
  } mts_regs_t;

  mts_regs_t s_reg;
  mts_regs_t s_next;

  logic bclk_fall;
  logic conv_fall;
  logic sar_bit;
  logic sar_end;

  assign bclk_fall = ~bclk_s & s_reg.bclk_d;
  // convert command is a falling edge
  assign conv_fall = ~conv_s & s_reg.conv_d;
  assign sar_bit   = sarv_s & ~s_reg.sarv_d;
  assign sar_end   = sare_s & ~s_reg.sare_d;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    s_next        = s_reg;
    s_next.bclk_d = bclk_s;
    s_next.conv_d = conv_s;
    s_next.sarv_d = sarv_s;
    s_next.sare_d = sare_s;

    // serial successive-approximation bits enter capture msb first
    if (sar_bit)
    begin
      s_next.capture = {s_reg.capture[mts_pkg::RESULT_W-2:0], sard_s}; // R01
    end
    // held latches the finished result and keeps it until the next convert
    if (sar_end)
    begin
      s_next.held = s_reg.capture; // R01
      s_next.busy = 1'b0;
    end

    case (s_reg.state)
      mts_pkg::MTS_IDLE:
      begin
        s_next.sync_act = 1'b0;
        if (conv_fall)
        begin
          // previous result leaves now, new conversion starts behind it
          s_next.out_sr  = {{mts_pkg::TAG_W{1'b0}}, s_reg.held}; // R02 R05
          s_next.busy    = 1'b1;
          s_next.bit_cnt = mts_pkg::CNT_ZERO;
          s_next.state   = mts_pkg::MTS_SYNC;
        end
      end
      mts_pkg::MTS_SYNC:
      begin
        // sync runs fall to fall so it straddles one rise, the far side's load edge
        if (bclk_fall)
        begin
          if (s_reg.sync_act)
          begin
            // msb leaves on the closing edge; first tag bit is taken here
            s_next.sync_act = 1'b0;
            s_next.serial_result_output     = s_reg.out_sr[mts_pkg::RESULT_W-1];           // R02
            s_next.out_sr   = {s_reg.out_sr[mts_pkg::FRAME_W-2:0], tag_s}; // R03
            s_next.state    = mts_pkg::MTS_SHIFT;
          end
          else
          begin
            s_next.sync_act = 1'b1;
          end
        end
      end
      mts_pkg::MTS_SHIFT:
      begin
        if (bclk_fall)
        begin
          // tag is taken mid-way between far-side rises; it enters at the bottom
          // and reaches the output right after the eighteenth data bit
          s_next.serial_result_output    = s_reg.out_sr[mts_pkg::RESULT_W-1];           // R02 R04
          s_next.out_sr  = {s_reg.out_sr[mts_pkg::FRAME_W-2:0], tag_s}; // R03
          s_next.bit_cnt = s_reg.bit_cnt + mts_pkg::CNT_ONE;
          if (s_reg.bit_cnt == mts_pkg::CNT_LAST)
          begin
            s_next.serial_result_output  = 1'b0;
            s_next.state = mts_pkg::MTS_IDLE;
          end
        end
      end
      default:
      begin
        s_next.state = mts_pkg::MTS_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      s_reg.state    <= mts_pkg::MTS_IDLE;
      s_reg.bclk_d   <= 1'b0;
      s_reg.conv_d   <= 1'b0;
      s_reg.sarv_d   <= 1'b0;
      s_reg.sare_d   <= 1'b0;
      s_reg.capture  <= mts_pkg::RESULT_RST;
      s_reg.held     <= mts_pkg::RESULT_RST;
      s_reg.out_sr   <= mts_pkg::FRAME_RST;
      s_reg.bit_cnt  <= mts_pkg::CNT_ZERO;
      s_reg.serial_result_output     <= 1'b0;
      s_reg.sync_act <= 1'b0;
      s_reg.busy     <= 1'b0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin polarity
  logic sync_pin_next;

  always_comb
  begin
    // low-true by default, high-true when format select strapped high
    if (fmt_s)
    begin
      sync_pin_next = s_next.sync_act; // R12
    end
    else
    begin
      sync_pin_next = ~s_next.sync_act; // R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; sync polarity registered so output is straight from a flop
  logic sync_pin_reg;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      sync_pin_reg <= 1'b1;
    end
    else
    begin
      sync_pin_reg <= sync_pin_next;
    end
  end

  assign O_FRAME_SYNC           = sync_pin_reg;
  assign O_SERIAL_RESULT_OUTPUT = s_reg.serial_result_output;
  assign O_BUSY                 = s_reg.busy;

endmodule : mts_converter

/* File: shared/mts_pkg.sv */
// Purpose: shared constants and types for the multichannel tag scanner converter side
// Assumes: 10 MHz system clock; link bit clock sampled as a plain input
// Notes:   result and tag widths are fixed; a frame is the result, then the tag
package mts_pkg;

  localparam int unsigned RESULT_W   = 18;
  localparam int unsigned TAG_W      = 3;
  localparam int unsigned FRAME_W    = RESULT_W + TAG_W;
  localparam int unsigned CNT_W      = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
  localparam logic [CNT_W-1:0] CNT_LAST = 5'h14;
  localparam logic [RESULT_W-1:0] RESULT_RST = 18'h00000;
  localparam logic [FRAME_W-1:0]  FRAME_RST  = 21'h000000;

  typedef enum logic [1:0] {
    MTS_IDLE  = 2'b00,
    MTS_SYNC  = 2'b01,
    MTS_SHIFT = 2'b11
  } mts_state_t;

endpackage : mts_pkg

/* File: rtl/mts_sync2.sv */
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: input is asynchronous to i_clk
// Notes:   first stage is read by the second stage only
`timescale 1ns/10ps
module mts_sync2
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_d,
  output logic      o_q
);

  logic meta_reg;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_reg <= 1'b0;
      o_q      <= 1'b0;
    end
    else
    begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end

endmodule : mts_sync2

/* File: test/mts_chk.sv */
// Purpose: port checks on mts_converter
// Assumes: bit clock is 8 system clocks
// Notes:   edge windows allow sync latency
`timescale 1ns/10ps
module mts_chk
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_BIT_CLK,
  input wire logic I_CONVERT,
  input wire logic I_SAR_DONE,
  input wire logic I_FRAME_FORMAT_SELECT,
  input wire logic O_SERIAL_RESULT_OUTPUT,
  input wire logic O_FRAME_SYNC,
  input wire logic O_BUSY
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_N);
  ////////////////////////////////////////
  sequence s_fell_seen;
    !$past(I_BIT_CLK, 2) || !$past(I_BIT_CLK, 4);
  endsequence
  property p_sync_low;
    $fell(O_FRAME_SYNC) && !I_FRAME_FORMAT_SELECT |-> ##[7:9] $rose(O_FRAME_SYNC);
  endproperty
  property p_sync_high;
    $rose(O_FRAME_SYNC) && I_FRAME_FORMAT_SELECT |-> ##[7:9] $fell(O_FRAME_SYNC);
  endproperty
  property p_sync_fall;
    $changed(O_FRAME_SYNC) && (O_FRAME_SYNC == I_FRAME_FORMAT_SELECT) |-> s_fell_seen;
  endproperty
  property p_serial_result_output_fall;
    $changed(O_SERIAL_RESULT_OUTPUT) |-> s_fell_seen;
  endproperty
  property p_busy_cause;
    $rose(O_BUSY) |-> !$past(I_CONVERT, 2);
  endproperty
  property p_busy_end;
    $rose(I_SAR_DONE) && O_BUSY |-> ##[1:6] !O_BUSY;
  endproperty
  a_sync_low: assert property (p_sync_low) else $error("sync pulse width");
  a_sync_high: assert property (p_sync_high) else $error("sync pulse width");
  a_sync_fall: assert property (p_sync_fall) else $error("sync off bit clock fall");
  a_serial_result_output_fall: assert property (p_serial_result_output_fall) else $error("serial_result_output off bit clock fall");
  a_busy_cause: assert property (p_busy_cause) else $error("busy without convert");
  a_busy_end: assert property (p_busy_end) else $error("busy not cleared");
endmodule : mts_chk
bind mts_converter mts_chk mts_chk_i (.*);

/* File: test/mts_far.sv */
// Purpose: scan, settle and tag logic model
// Assumes: free-running bit clock
// Notes:   tag loads at the bit-clock rise that falls inside sync
`timescale 1ns/10ps
module mts_far
#(
  parameter int SETTLE = 20
)
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_step,
  input  wire logic i_sync,
  input  wire logic i_fmt,
  output logic      o_bclk,
  output logic      o_convert,
  output logic      o_tag
);
  logic [2:0] chan_reg;
  logic [2:0] id_reg;
  logic [2:0] tag_reg;
  int         tmr;
  ////////////////////////////////////////
  initial
  begin
    o_bclk = 1'b0;
    #137;
    forever #400 o_bclk = ~o_bclk;
  end
  always @(negedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      chan_reg  <= 3'h7;
      tmr       <= 0;
      o_convert <= 1'b1;
    end
    else if (i_step)
    begin
      chan_reg <= chan_reg + 3'h1;
      tmr      <= SETTLE + 16;
    end
    else if (tmr > 0)
    begin
      tmr       <= tmr - 1;
      o_convert <= (tmr > 16) || (tmr == 1);
    end
  // sync straddles exactly one rise, which is the load point
  always @(posedge o_bclk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      id_reg  <= 3'h0;
      tag_reg <= 3'h0;
    end
    else if (i_sync == i_fmt)
    begin
      id_reg  <= chan_reg;
      tag_reg <= id_reg;
    end
    else
      tag_reg <= {tag_reg[1:0], 1'b0};
  assign o_tag = tag_reg[2];
endmodule : mts_far

/* File: test/multichannel_tag_scanner_test.sv */
// Purpose: scan frames in both sync formats
// Assumes: settle shortened to 20 cycles
// Notes:   frame bits sampled mid bit period
`timescale 1ns/10ps
module multichannel_tag_scanner_test;
  logic        clk, rst_n, step, sar_d, sar_v, sar_done, fmt, bclk, conv, tag, serial_result_output, sync, busy;
  int          error_cnt, checked, cyc;
  logic [17:0] res [0:9];
  ////////////////////////////////////////
  mts_converter mts_converter_i (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_BIT_CLK(bclk),
    .I_CONVERT(conv), .I_SAR_DATA(sar_d), .I_SAR_VALID(sar_v), .I_SAR_DONE(sar_done),
    .I_TAG(tag), .I_FRAME_FORMAT_SELECT(fmt), .O_SERIAL_RESULT_OUTPUT(serial_result_output),
    .O_FRAME_SYNC(sync), .O_BUSY(busy));
  mts_far mts_far_i (.i_clk(clk), .i_rst_n(rst_n), .i_step(step), .i_sync(sync),
    .i_fmt(fmt), .o_bclk(bclk), .o_convert(conv), .o_tag(tag));
  always #50 clk = ~clk;
  task automatic check(input logic [20:0] seen, input logic [20:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic reset_dut(input logic f);
    // release after a rise so the reset-level sync is gone before the next one
    if (f) @(posedge bclk);
    @(negedge clk);
    rst_n = 1'b0;
    fmt = f;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    check({20'h0, sync}, {20'h0, ~f});
  endtask : reset_dut
  task automatic convert_once(input int k, input logic f);
    int          n;
    logic [20:0] got;
    res[k] = 18'h2A5C3 + 18'h1357F * k[17:0];
    // nba: the far model samples step on this same edge
    @(negedge clk);
    step <= 1'b1;
    @(negedge clk);
    step <= 1'b0;
    for (n = 0; n < 100 && conv !== 1'b0; n++) @(negedge clk);
    fork
      begin
        repeat (6) @(negedge clk);
        for (int i = 17; i >= 0; i--)
        begin
          sar_d = res[k][i];
          sar_v = 1'b1;
          repeat (2) @(negedge clk);
          sar_v = 1'b0;
          repeat (2) @(negedge clk);
        end
        check({20'h0, busy}, 21'h000001);
        sar_done = 1'b1;
        repeat (2) @(negedge clk);
        sar_done = 1'b0;
        repeat (2) @(negedge clk);
        check({20'h0, busy}, 21'h000000);
      end
      begin
        for (n = 0; n < 200 && sync !== f; n++) @(negedge clk);
        // msb starts as sync ends; first sample at the rise after that
        for (n = 0; n < 20 && sync === f; n++) @(negedge clk);
        for (int i = 20; i >= 0; i--)
        begin
          @(posedge bclk);
          #200 got[i] = serial_result_output;
        end
      end
    join
    check(got, (k == 0) ? {mts_pkg::RESULT_RST, 3'h0} : {res[k-1], 3'(k - 1)});
    repeat (2) @(posedge bclk);
  endtask : convert_once
  task automatic scan_default;
    reset_dut(1'b0);
    for (int k = 0; k < 10; k++) convert_once(k, 1'b0);
  endtask : scan_default
  task automatic scan_inverted;
    reset_dut(1'b1);
    for (int k = 0; k < 10; k++) convert_once(k, 1'b1);
  endtask : scan_inverted
  initial
  begin
    {clk, rst_n, step, sar_d, sar_v, sar_done, fmt} = 7'h00;
    scan_default();
    scan_inverted();
    finish_test();
  end
endmodule : multichannel_tag_scanner_test
